// ===== dv/prcs_peer_model.sv
/*
  Peer on the inter-device bus: sends one-cycle events.
  Assumes the bench clock; drives at the falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module prcs_peer_model (
  // Clock and events
  input  wire logic                    clk,
  output var prcs_pkg::prcs_event_type ev
);
  import prcs_pkg::*;
  initial ev = '0;
  task automatic send(input prcs_kind_type k, input logic [4:0] id,
                      input logic [15:0] d);
    @(negedge clk);
    ev = '{1'h1, k, id, d};
    @(negedge clk);
    ev = '{1'h0, k, ~id, ~d}; // Idle bus shows inverted id and data; kind keeps its last value
  endtask
endmodule // prcs_peer_model
`default_nettype wire

// ===== dv/tb_top.sv
/*
  Bench for the rail configuration bank, with a register model.
  Assumes the peer model and a 125 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import prcs_pkg::*;
  localparam logic [127:0] IDS = 128'h54455354; // Arbitrary value
  logic [7:0] cd[8] = '{CMD_USER_FEATURE, CMD_RAIL_IDENT, CMD_GOOD_DELAY,
    CMD_LOOP_TUNE, CMD_RAIL_ORDER, CMD_TRACK_MODE, CMD_GROUP_MEMB,
    CMD_OC_RETRY};
  logic [31:0] rv[8] = '{USER_RESET, IDENT_RESET, DELAY_RESET, LOOP_RESET,
    ORDER_RESET, TRACK_RESET, GROUP_RESET, OC_RESET};
  logic [31:0] mk[8] = '{USER_MASK, IDENT_MASK, 32'hFFFF, LOOP_MASK,
    ORDER_MASK, 32'h0, GROUP_MASK, OC_MASK};
  logic clk, rst_n, rd_valid, cmd_err, rail_on, oc_status, pg_out, pg_oe;
  logic enable_request, oc_fault, clear_faults, gvp, gop, den, xen;
  logic pg_above, bias_ok, lte;
  logic [2:0]     ph, nd;
  logic [4:0]     rid, strap;
  logic [7:0]     lres;
  logic [15:0]    lgain;
  prcs_event_type evo;
  logic [127:0]   rd_data;
  logic [7:0]     min_duty;
  logic [15:0]    group_data;
  logic [31:0]    d;
  prcs_cmd_type   cmd;
  prcs_event_type ev_in;
  int             error_cnt, n_compared, n;
  prcs_rail_config #(.MS_CYC(20), .ID_STRING(IDS)) i_prcs_rail_config (
    .clk(clk), .rst_n(rst_n), .cmd(cmd), .rd_valid(rd_valid),
    .rd_data(rd_data), .cmd_err(cmd_err), .ev_in(ev_in), .ev_out(evo),
    .enable_request(enable_request), .bias_ok(bias_ok), .other_fault(1'h0),
    .oc_fault(oc_fault), .clear_faults(clear_faults), .pg_above(pg_above),
    .cfg_strap(strap), .rail_on(rail_on), .oc_status(oc_status),
    .pg_out(pg_out), .pg_oe(pg_oe), .min_duty(min_duty),
    .min_duty_en(den), .ext_temp_en(xen), .phase_pos(ph), .rail_id(rid),
    .rail_devices(nd), .loop_tune_en(lte), .loop_residual(lres),
    .loop_gain(lgain),
    .group_vout_pulse(gvp), .group_op_pulse(gop), .group_data(group_data));
  prcs_peer_model i_prcs_peer_model (.clk(clk), .ev(ev_in));
  task automatic chk(input logic [127:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [31:0] v);
    @(negedge clk);
    cmd = '{1'h1, w, c, v};
    @(negedge clk);
    cmd.valid = 1'h0;
  endtask
  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  initial begin
    #(8 * 20000);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    {cmd, enable_request, oc_fault, clear_faults, rst_n, pg_above} = '0;
    bias_ok = 1'h1;
    strap   = 5'h1D;
    void'($urandom(49));
    repeat (6) @(negedge clk);
    rst_n = 1'h1;
    foreach (cd[i]) begin
      xfer(1'h0, cd[i], 32'h0);
      chk(rd_data, rv[i]);
      d = $urandom;
      xfer(1'h1, cd[i], d);
      xfer(1'h0, cd[i], 32'h0);
      chk(rd_data, (d & mk[i]) | (rv[i] & ~mk[i]));
    end
    rst_n = 1'h0;
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    $display("register test done");
    repeat (4) @(negedge clk);
    chk({min_duty, den, xen}, {DUTY_CODE3, 2'h3});
    for (int k = 0; k < 4; k++) begin
      xfer(1'h1, CMD_USER_FEATURE, {k[1:0], k[0] ? 3'h2 : 3'h5});
      @(negedge clk);
      chk({min_duty, den, xen, pg_oe, pg_out},
          {8'(39 * (k + 1)), ~k[0], ~k[0], 2'h2});
    end
    xfer(1'h1, CMD_TRACK_MODE, 32'hFF);
    chk(cmd_err, 1'h1);
    xfer(1'h0, CMD_IDENT_STR, 32'h0);
    chk(rd_data, IDS);
    xfer(1'h1, CMD_GROUP_MEMB, 32'h00250000);
    i_prcs_peer_model.send(EV_GROUP_VOUT, 5'h05, 16'h1234);
    chk({gvp, group_data}, {1'h1, 16'h1234});
    i_prcs_peer_model.send(EV_GROUP_VOUT, 5'h06, 16'h5678);
    chk({gvp, group_data}, {1'h0, 16'h1234});
    i_prcs_peer_model.send(EV_GROUP_OP, 5'h00, 16'h0001);
    chk(gop, 1'h0);
    $display("feature and group test done");
    xfer(1'h1, CMD_RAIL_IDENT, 32'hA503);
    xfer(1'h1, CMD_RAIL_ORDER, 32'h8300);
    xfer(1'h1, CMD_GOOD_DELAY, 32'h0);
    enable_request = 1'h1;
    repeat (2) @(negedge clk);
    chk({rail_on, ph, rid, nd, lte, lres, lgain},
        {4'h5, 5'h05, 3'h3, LOOP_RESET[24:0]});
    i_prcs_peer_model.send(EV_POWER_GOOD, 5'h03, 16'h0);
    @(negedge clk);
    chk(rail_on, 1'h1);
    pg_above = 1'h1;
    repeat (3) @(negedge clk);
    chk({pg_oe, pg_out, evo},
        {2'h3, 1'h1, EV_POWER_GOOD, 5'h05, 16'h0});
    xfer(1'h1, CMD_USER_FEATURE, 32'h0);
    @(negedge clk);
    chk({pg_oe, pg_out}, 2'h0);
    pg_above = 1'h0;
    xfer(1'h1, CMD_GOOD_DELAY, 32'(DELAY_RESET));
    pg_above = 1'h1;
    repeat (200) @(negedge clk);
    chk({pg_oe, pg_out}, 2'h2);
    $display("power-good test done");
    for (int r = 0; r < 2; r++) begin
      repeat (20) @(negedge clk);
      chk(rail_on, 1'h1);
      oc_fault = 1'h1;
      @(negedge clk);
      oc_fault = 1'h0;
      chk({oc_status, rail_on}, 2'h2);
      n = 0;
      while (!rail_on && n < 2000) begin
        @(negedge clk);
        n++;
      end
      chk(r ? (n > 1370 && n < 1430) : n == 2000, 1'h1);
      clear_faults = 1'h1;
      xfer(1'h1, CMD_OC_RETRY, 32'h39);
      clear_faults = 1'h0;
    end
    $display("overcurrent test done");
    bias_ok = 1'h0;
    @(negedge clk);
    chk(rail_on, 1'h0);
    bias_ok = 1'h1;
    xfer(1'h1, CMD_GROUP_MEMB, 32'h00000024);
    i_prcs_peer_model.send(EV_POWER_FAIL, 5'h04, 16'h0);
    chk(rail_on, 1'h0);
    repeat (8) @(negedge clk);
    chk(rail_on, 1'h0);
    enable_request = 1'h0;
    xfer(1'h1, CMD_RAIL_ORDER, 32'h8387);
    enable_request = 1'h1;
    repeat (4) @(negedge clk);
    chk(rail_on, 1'h1);
    i_prcs_peer_model.send(EV_POWER_DOWN, 5'h07, 16'h0);
    chk(rail_on, 1'h1);
    repeat (30) @(negedge clk);
    chk(rail_on, 1'h0);
    $display("sequencing test done");
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire

// ===== shared/prcs_pkg.sv
/*
  Package for the rail configuration and sequencing command bank:
  command codes, field positions, masks, reset values, timing counts
  and the carrier types. Assumes a 125 MHz clock.
*/
package prcs_pkg;

  // Command codes
  localparam logic [7:0] CMD_USER_FEATURE = 8'hD1;
  localparam logic [7:0] CMD_RAIL_IDENT   = 8'hD3;
  localparam logic [7:0] CMD_GOOD_DELAY   = 8'hD4;
  localparam logic [7:0] CMD_LOOP_TUNE    = 8'hDF;
  localparam logic [7:0] CMD_RAIL_ORDER   = 8'hE0;
  localparam logic [7:0] CMD_TRACK_MODE   = 8'hE1;
  localparam logic [7:0] CMD_GROUP_MEMB   = 8'hE2;
  localparam logic [7:0] CMD_IDENT_STR    = 8'hE4;
  localparam logic [7:0] CMD_OC_RETRY     = 8'hE5;

  // Reset values and writable masks
  localparam logic [7:0]  USER_RESET  = 8'h00;
  localparam logic [7:0]  USER_MASK   = 8'h1F;
  localparam logic [15:0] IDENT_RESET = 16'h0000;
  localparam logic [15:0] IDENT_MASK  = 16'hFF07;
  localparam logic [15:0] DELAY_RESET = 16'h0001;
  localparam logic [31:0] LOOP_RESET  = 32'h01500258;
  localparam logic [31:0] LOOP_MASK   = 32'h01FFFFFF;
  localparam logic [15:0] ORDER_RESET = 16'h0000;
  localparam logic [15:0] ORDER_MASK  = 16'h9F9F;
  localparam logic [7:0]  TRACK_RESET = 8'h00;
  localparam logic [31:0] GROUP_RESET = 32'h00000000;
  localparam logic [31:0] GROUP_MASK  = 32'h003F3F3F;
  localparam logic [7:0]  OC_RESET    = 8'h80;
  localparam logic [7:0]  OC_MASK     = 8'h3F;
  localparam logic [7:0]  OC_FIXED    = 8'h80;

  // Field positions
  localparam int UF_DUTY_LSB = 3;
  localparam int UF_DUTY_EN  = 2;
  localparam int UF_PG_PP    = 1;
  localparam int UF_EXTERNAL_TEMP_SENSE    = 0;
  localparam int RI_PHASE    = 13;
  localparam int RI_RAIL     = 8;
  localparam int RI_COUNT    = 0;
  localparam int LT_EN       = 24;
  localparam int LT_RES      = 16;
  localparam int LT_GAIN     = 0;
  localparam int RO_PRE_EN   = 15;
  localparam int RO_PRE      = 8;
  localparam int RO_SEQ_EN   = 7;
  localparam int RO_SEQ      = 0;
  localparam int GM_VOUT_EN  = 21;
  localparam int GM_VOUT     = 16;
  localparam int GM_OP_EN    = 13;
  localparam int GM_OP       = 8;
  localparam int GM_PF_IMM   = 5;
  localparam int GM_PF       = 0;
  localparam int OC_MODE     = 3;
  localparam int OC_DELAY    = 0;
  localparam int L11_EXP     = 11;
  localparam logic [2:0] OC_MODE_LATCH = 3'h0;
  localparam logic [2:0] OC_MODE_RETRY = 3'h7;

  // Minimum duty in hundredths of a percent
  localparam logic [7:0] DUTY_CODE0 = 8'h27;
  localparam logic [7:0] DUTY_CODE1 = 8'h4E;
  localparam logic [7:0] DUTY_CODE2 = 8'h75;
  localparam logic [7:0] DUTY_CODE3 = 8'h9C;

  // Timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int PG_STEP_NS     = 125;
  localparam int PG_STEP_CYCLES = (PG_STEP_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int MS_NS          = 1000000;
  localparam int MS_CYCLES      = MS_NS / CLK_PERIOD_NS;
  localparam int PG_STEPS_MS    = MS_NS / PG_STEP_NS;
  localparam int PG_MAX_MS      = 5000;
  localparam logic [41:0] PG_MAX_STEPS = 42'(PG_MAX_MS * PG_STEPS_MS);
  localparam int RETRY_UNIT_MS  = 35;

  typedef enum logic [2:0] {
    EV_POWER_GOOD, EV_POWER_DOWN, EV_POWER_FAIL, EV_GROUP_VOUT, EV_GROUP_OP
  } prcs_kind_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [31:0] wdata;
  } prcs_cmd_type;

  typedef struct packed {
    logic          valid;
    prcs_kind_type kind;
    logic [4:0]    id;
    logic [15:0]   data;
  } prcs_event_type;

  typedef enum {
    S_OFF, S_PREQ, S_ON, S_SOFT_OFF, S_FAULT_HOLD, S_RETRY_WAIT
  } prcs_state_type;

endpackage

// ===== verilog/prcs_rail_config.sv
/*
  Rail configuration command bank with power-good delay, multi-rail
  sequencing, broadcast group handling and overcurrent retry.
  Assumes commands and inter-device bus events arrive on clk; the
  comparator and strap pins are asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none

module prcs_rail_config #(
  parameter int          MS_CYC       = prcs_pkg::MS_CYCLES,
  parameter int          OFF_DELAY_MS = 1,
  parameter logic [127:0] ID_STRING   = 128'h5241494C4346475F44305F4630313030
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Command port
  input  wire prcs_pkg::prcs_cmd_type   cmd,
  output logic                          rd_valid,
  output logic [127:0]                  rd_data,
  output logic                          cmd_err,
  // Inter-device bus
  input  wire prcs_pkg::prcs_event_type ev_in,
  output prcs_pkg::prcs_event_type      ev_out,
  // Regulator control and status
  input  wire logic                     enable_request,
  input  wire logic                     bias_ok,
  input  wire logic                     other_fault,
  input  wire logic                     oc_fault,
  input  wire logic                     clear_faults,
  input  wire logic                     pg_above,
  input  wire logic [4:0]               cfg_strap,
  output logic                          rail_on,
  output logic                          oc_status,
  // Power-good pin
  output logic                          pg_out,
  output logic                          pg_oe,
  // Settings to the regulator
  output logic [7:0]                    min_duty,
  output logic                          min_duty_en,
  output logic                          ext_temp_en,
  output logic [2:0]                    phase_pos,
  output logic [4:0]                    rail_id,
  output logic [2:0]                    rail_devices,
  output logic                          loop_tune_en,
  output logic [7:0]                    loop_residual,
  output logic [15:0]                   loop_gain,
  output logic                          group_vout_pulse,
  output logic                          group_op_pulse,
  output logic [15:0]                   group_data
);
  import prcs_pkg::*;

  // ID_STRING default is arbitrary
  function automatic logic [7:0] duty_of(input logic [1:0] code);
    case (code)
      2'h0:    duty_of = DUTY_CODE0;
      2'h1:    duty_of = DUTY_CODE1;
      2'h2:    duty_of = DUTY_CODE2;
      default: duty_of = DUTY_CODE3;
    endcase
  endfunction

  function automatic logic [41:0] steps_of(input logic [15:0] v);
    logic [41:0] p;
    logic [4:0]  n;
    p = 42'(v[9:0]) * 42'(PG_STEPS_MS);
    n = v[15:L11_EXP];
    if (v[L11_EXP-1]) begin
      p = '0;
    end else if (n[4]) begin
      p = p >> (5'(-n));
    end else begin
      p = p << n[3:0];
    end
    steps_of = (p > PG_MAX_STEPS) ? PG_MAX_STEPS : p;
  endfunction

  // Register state
  logic [7:0]  user_feat, next_user_feat;
  logic        user_written, next_user_written;
  logic [15:0] ident, next_ident;
  logic [15:0] good_delay, next_good_delay;
  logic [31:0] loop_word, next_loop_word;
  logic [15:0] order, next_order;
  logic [31:0] group, next_group;
  logic [7:0]  oc_policy, next_oc_policy;
  logic        next_rd_valid, next_cmd_err;
  logic [127:0] next_rd_data;
  logic [4:0]  feat_eff;

  always_comb begin
    next_user_feat    = user_feat;
    next_user_written = user_written;
    next_ident        = ident;
    next_good_delay   = good_delay;
    next_loop_word    = loop_word;
    next_order        = order;
    next_group        = group;
    next_oc_policy    = oc_policy;
    next_rd_valid     = cmd.valid && !cmd.write;
    next_rd_data      = '0;
    next_cmd_err      = 1'b0;
    if (cmd.valid && cmd.write) begin
      case (cmd.code)
        CMD_USER_FEATURE: begin
          next_user_feat    = cmd.wdata[7:0] & USER_MASK;
          next_user_written = 1'b1;
        end
        CMD_RAIL_IDENT: next_ident = cmd.wdata[15:0] & IDENT_MASK;
        CMD_GOOD_DELAY: next_good_delay = cmd.wdata[15:0];
        CMD_LOOP_TUNE:  next_loop_word = cmd.wdata & LOOP_MASK;
        CMD_RAIL_ORDER: next_order = cmd.wdata[15:0] & ORDER_MASK;
        CMD_GROUP_MEMB: next_group = cmd.wdata & GROUP_MASK;
        CMD_OC_RETRY:
          next_oc_policy = (cmd.wdata[7:0] & OC_MASK) | OC_FIXED;
        default: next_cmd_err = 1'b1;
      endcase
    end else if (cmd.valid) begin
      case (cmd.code)
        CMD_USER_FEATURE: next_rd_data = 128'(user_feat);
        CMD_RAIL_IDENT:   next_rd_data = 128'(ident);
        CMD_GOOD_DELAY:   next_rd_data = 128'(good_delay);
        CMD_LOOP_TUNE:    next_rd_data = 128'(loop_word);
        CMD_RAIL_ORDER:   next_rd_data = 128'(order);
        CMD_TRACK_MODE:   next_rd_data = 128'(TRACK_RESET);
        CMD_GROUP_MEMB:   next_rd_data = 128'(group);
        CMD_IDENT_STR:    next_rd_data = ID_STRING;
        CMD_OC_RETRY:     next_rd_data = 128'(oc_policy);
        default:          next_cmd_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      user_feat    <= USER_RESET;
      user_written <= 1'b0;
      ident        <= IDENT_RESET;
      good_delay   <= DELAY_RESET;
      loop_word    <= LOOP_RESET;
      order        <= ORDER_RESET;
      group        <= GROUP_RESET;
      oc_policy    <= OC_RESET;
      rd_valid     <= 1'b0;
      rd_data      <= '0;
      cmd_err      <= 1'b0;
    end else begin
      user_feat    <= next_user_feat;
      user_written <= next_user_written;
      ident        <= next_ident;
      good_delay   <= next_good_delay;
      loop_word    <= next_loop_word;
      order        <= next_order;
      group        <= next_group;
      oc_policy    <= next_oc_policy;
      rd_valid     <= next_rd_valid;
      rd_data      <= next_rd_data;
      cmd_err      <= next_cmd_err;
    end
  end

  // Pin synchronisers and strap capture
  logic       pg_meta, pg_sync;
  logic [4:0] strap_meta, strap_sync, strap_val;
  logic       strap_taken;
  logic [1:0] strap_age;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pg_meta     <= 1'b0;
      pg_sync     <= 1'b0;
      strap_meta  <= '0;
      strap_sync  <= '0;
      strap_val   <= '0;
      strap_taken <= 1'b0;
      strap_age   <= '0;
    end else begin
      pg_meta     <= pg_above;
      pg_sync     <= pg_meta;
      strap_meta  <= cfg_strap;
      strap_sync  <= strap_meta;
      strap_age   <= {strap_age[0], 1'b1};
      // Take the strap only once both synchroniser stages hold the pin
      if (&strap_age && !strap_taken) begin
        strap_val   <= strap_sync;
        strap_taken <= 1'b1;
      end
    end
  end

  assign feat_eff = user_written ? user_feat[4:0] : strap_val;

  // Settings outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      min_duty      <= DUTY_CODE0;
      min_duty_en   <= 1'b0;
      ext_temp_en   <= 1'b0;
      phase_pos     <= '0;
      rail_id       <= '0;
      rail_devices  <= '0;
      loop_tune_en  <= 1'b0;
      loop_residual <= '0;
      loop_gain     <= '0;
    end else begin
      min_duty      <= duty_of(feat_eff[UF_DUTY_LSB +: 2]);
      min_duty_en   <= feat_eff[UF_DUTY_EN];
      ext_temp_en   <= feat_eff[UF_EXTERNAL_TEMP_SENSE];
      phase_pos     <= ident[RI_PHASE +: 3];
      rail_id       <= ident[RI_RAIL +: 5];
      rail_devices  <= ident[RI_COUNT +: 3];
      loop_tune_en  <= loop_word[LT_EN];
      loop_residual <= loop_word[LT_RES +: 8];
      loop_gain     <= loop_word[LT_GAIN +: 16];
    end
  end

  // Step and millisecond enables
  logic [4:0]  step_cnt, next_step_cnt;
  logic [31:0] ms_cnt, next_ms_cnt;
  logic        step_tick, ms_tick;

  assign step_tick = (step_cnt == 5'(PG_STEP_CYCLES - 1));
  assign ms_tick   = (ms_cnt == 32'(MS_CYC - 1));

  always_comb begin
    next_step_cnt = step_tick ? '0 : step_cnt + 5'h01;
    next_ms_cnt   = ms_tick ? '0 : ms_cnt + 32'h00000001;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      step_cnt <= '0;
      ms_cnt   <= '0;
    end else begin
      step_cnt <= next_step_cnt;
      ms_cnt   <= next_ms_cnt;
    end
  end

  // Sequencer
  prcs_state_type state, next_state;
  logic [8:0]  wait_ms, next_wait_ms;
  logic        prequel_seen, next_prequel_seen;
  logic        shut_hold, next_shut_hold;
  logic        next_rail_on, next_oc_status;
  logic        pre_match, seq_match, pf_match, oc_hit, retry_mode;

  assign pre_match = ev_in.valid && (ev_in.id == order[RO_PRE +: 5]);
  assign seq_match = ev_in.valid && order[RO_SEQ_EN]
                     && ev_in.kind == EV_POWER_DOWN
                     && ev_in.id == order[RO_SEQ +: 5];
  assign pf_match  = ev_in.valid && ev_in.kind == EV_POWER_FAIL
                     && ev_in.id == group[GM_PF +: 5];
  assign oc_hit    = oc_fault && rail_on;
  assign retry_mode = oc_policy[OC_MODE +: 3] == OC_MODE_RETRY;

  always_comb begin
    next_state        = state;
    next_wait_ms      = wait_ms;
    next_prequel_seen = prequel_seen;
    // A commanded shutdown stays off until the enable state drops
    next_shut_hold    = shut_hold && enable_request;
    if (pre_match && ev_in.kind == EV_POWER_GOOD) begin
      next_prequel_seen = 1'b1;
    end else if (pre_match && ev_in.kind == EV_POWER_DOWN) begin
      next_prequel_seen = 1'b0;
    end
    case (state)
      S_OFF: begin
        if (enable_request && bias_ok && !other_fault && !shut_hold) begin
          next_state = order[RO_PRE_EN] ? S_PREQ : S_ON;
        end
      end
      S_PREQ: begin
        if (!enable_request) begin
          next_state = S_OFF;
        end else if (prequel_seen) begin
          next_state = S_ON;
        end
      end
      S_ON: begin
        if (oc_fault) begin
          next_state   = retry_mode ? S_RETRY_WAIT : S_FAULT_HOLD;
          next_wait_ms = 9'(({6'h00, oc_policy[OC_DELAY +: 3]} + 9'h001)
                         * 9'(RETRY_UNIT_MS));
        end else if (!enable_request || !bias_ok || other_fault) begin
          next_state = S_OFF;
        end else if (pf_match && group[GM_PF_IMM]) begin
          next_state     = S_OFF;
          next_shut_hold = 1'b1;
        end else if (pf_match || seq_match) begin
          next_state   = S_SOFT_OFF;
          next_wait_ms = 9'(OFF_DELAY_MS);
        end
      end
      S_SOFT_OFF: begin
        if (ms_tick) begin
          next_wait_ms = wait_ms - 9'h001;
        end
        if (wait_ms == '0) begin
          next_state     = S_OFF;
          next_shut_hold = 1'b1;
        end
      end
      S_FAULT_HOLD: begin
        if (clear_faults) begin
          next_state = S_OFF;
        end
      end
      S_RETRY_WAIT: begin
        if (ms_tick) begin
          next_wait_ms = wait_ms - 9'h001;
        end
        if (!enable_request) begin
          next_state = S_OFF;
        end else if (!bias_ok || other_fault) begin
          next_state = S_FAULT_HOLD;
        end else if (wait_ms == '0) begin
          next_state = S_ON;
        end
      end
      default: next_state = S_OFF;
    endcase
    next_rail_on   = (next_state == S_ON) || (next_state == S_SOFT_OFF);
    next_oc_status = oc_hit || (oc_status && !clear_faults);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state        <= S_OFF;
      wait_ms      <= '0;
      prequel_seen <= 1'b0;
      shut_hold    <= 1'b0;
      rail_on      <= 1'b0;
      oc_status    <= 1'b0;
    end else begin
      state        <= next_state;
      wait_ms      <= next_wait_ms;
      prequel_seen <= next_prequel_seen;
      shut_hold    <= next_shut_hold;
      rail_on      <= next_rail_on;
      oc_status    <= next_oc_status;
    end
  end

  // Power-good delay, pin drive, bus events and broadcasts
  logic [41:0]    pg_steps, next_pg_steps;
  logic           pg_good, next_pg_good;
  logic           rail_on_d;
  logic           next_pg_out, next_pg_oe;
  prcs_event_type next_ev_out;
  logic           next_gv, next_go;
  logic [15:0]    next_group_data;

  always_comb begin
    next_pg_steps = pg_steps;
    next_pg_good  = pg_good;
    if (!pg_sync || !rail_on) begin
      next_pg_steps = '0;
      next_pg_good  = 1'b0;
    end else if (pg_steps >= steps_of(good_delay)) begin
      next_pg_good  = 1'b1;
    end else if (step_tick) begin
      next_pg_steps = pg_steps + 42'h1;
    end
    next_pg_oe  = feat_eff[UF_PG_PP] ? 1'b1 : !next_pg_good;
    next_pg_out = feat_eff[UF_PG_PP] ? next_pg_good : 1'b0;
    next_ev_out = '0;
    if (next_pg_good && !pg_good) begin
      next_ev_out.valid = 1'b1;
      next_ev_out.kind  = EV_POWER_GOOD;
      next_ev_out.id    = ident[RI_RAIL +: 5];
    end else if (!rail_on && rail_on_d) begin
      next_ev_out.valid = 1'b1;
      next_ev_out.kind  = EV_POWER_DOWN;
      next_ev_out.id    = ident[RI_RAIL +: 5];
    end
    next_gv = ev_in.valid && ev_in.kind == EV_GROUP_VOUT && group[GM_VOUT_EN]
              && ev_in.id == group[GM_VOUT +: 5];
    next_go = ev_in.valid && ev_in.kind == EV_GROUP_OP && group[GM_OP_EN]
              && ev_in.id == group[GM_OP +: 5];
    next_group_data = (next_gv || next_go) ? ev_in.data : group_data;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pg_steps         <= '0;
      pg_good          <= 1'b0;
      rail_on_d        <= 1'b0;
      pg_out           <= 1'b0;
      pg_oe            <= 1'b1;
      ev_out           <= '0;
      group_vout_pulse <= 1'b0;
      group_op_pulse   <= 1'b0;
      group_data       <= '0;
    end else begin
      pg_steps         <= next_pg_steps;
      pg_good          <= next_pg_good;
      rail_on_d        <= rail_on;
      pg_out           <= next_pg_out;
      pg_oe            <= next_pg_oe;
      ev_out           <= next_ev_out;
      group_vout_pulse <= next_gv;
      group_op_pulse   <= next_go;
      group_data       <= next_group_data;
    end
  end

  // Checks
  sequence s_feat_write;
    cmd.valid && cmd.write && cmd.code == CMD_USER_FEATURE;
  endsequence
  sequence s_ident_read;
    cmd.valid && !cmd.write && cmd.code == CMD_IDENT_STR;
  endsequence

  property p_duty;
    @(posedge clk) disable iff (!rst_n)
    s_feat_write |-> ##2 min_duty == duty_of($past(cmd.wdata[4:3], 2))
      && min_duty_en == $past(cmd.wdata[2], 2);
  endproperty
  a_duty: assert property (p_duty) else $error("duty setting wrong");
  property p_external_temp_sense;
    @(posedge clk) disable iff (!rst_n)
    s_feat_write |-> ##2 ext_temp_en == $past(cmd.wdata[0], 2);
  endproperty
  a_external_temp_sense: assert property (p_external_temp_sense) else $error("external_temp_sense wrong");
  property p_pg_drive;
    @(posedge clk) disable iff (!rst_n)
    (!feat_eff[UF_PG_PP] && !$past(feat_eff[UF_PG_PP])) |-> !pg_out;
  endproperty
  a_pg_drive: assert property (p_pg_drive) else $error("pg drive");
  property p_pg_delay;
    @(posedge clk) disable iff (!rst_n)
    $rose(pg_good) |-> $past(pg_steps) >= steps_of($past(good_delay));
  endproperty
  a_pg_delay: assert property (p_pg_delay) else $error("pg early");
  property p_prequel;
    @(posedge clk) disable iff (!rst_n)
    $rose(rail_on) && order[RO_PRE_EN] && !$past(oc_fault, 2)
      |-> $past(prequel_seen) && $past(enable_request);
  endproperty
  a_prequel: assert property (p_prequel) else $error("prequel");
  property p_sequel;
    @(posedge clk) disable iff (!rst_n)
    state == S_ON && seq_match && !oc_fault && enable_request && bias_ok
      && !other_fault && !pf_match |=> state == S_SOFT_OFF;
  endproperty
  a_sequel: assert property (p_sequel) else $error("sequel");
  property p_vout;
    @(posedge clk) disable iff (!rst_n)
    ev_in.valid && ev_in.kind == EV_GROUP_VOUT && !group[GM_VOUT_EN]
      |=> !group_vout_pulse;
  endproperty
  a_vout: assert property (p_vout) else $error("vout ignored");
  property p_op;
    @(posedge clk) disable iff (!rst_n)
    ev_in.valid && ev_in.kind == EV_GROUP_OP && group[GM_OP_EN]
      && ev_in.id == group[GM_OP +: 5] |=> group_op_pulse;
  endproperty
  a_op: assert property (p_op) else $error("op missed");
  property p_pf_now;
    @(posedge clk) disable iff (!rst_n)
    state == S_ON && pf_match && group[GM_PF_IMM] |=> !rail_on ##1 !rail_on;
  endproperty
  a_pf_now: assert property (p_pf_now) else $error("pf slow");
  property p_ident;
    @(posedge clk) disable iff (!rst_n)
    s_ident_read |=> rd_valid && rd_data == ID_STRING;
  endproperty
  a_ident: assert property (p_ident) else $error("ident");
  property p_latch;
    @(posedge clk) disable iff (!rst_n)
    state == S_FAULT_HOLD && !clear_faults |=> !rail_on && oc_status;
  endproperty
  a_latch: assert property (p_latch) else $error("latched off");
  property p_reserved;
    @(posedge clk) disable iff (!rst_n)
    cmd.valid && !cmd.write && cmd.code == CMD_OC_RETRY
      |=> rd_data[7:6] == 2'h2 && rd_data[127:8] == '0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved");

endmodule // prcs_rail_config

`default_nettype wire
